// File: src/acs_aux_clock.sv
// Contract
// R1: Pins pick C: ref, ref/2, ref/4.
// R2: Clock wins; else flag enable picks over-range.
// R3: Pins only enable D, undivided reference.
// R4: Override on: select fields choose function.
// R5: D clock only while C clock enabled.
// R6: Single clock consumer uses output C.
// R7: Strapped clock runs from power-up, no access.
// R8: Power-down pin high disables both outputs.
// R9: Timing reference caught on deterministic edge.
// R10: Capture through window logic, not fixed edge.
// R11: Single pulse or periodic reference both work.
// R12: 8b/10b periodic rate divides multiframe clock.
// R13: 64b/66b periodic rate divides extended multiblock.
// R14: Detect position, user picks delayed sample.
// R15: Map has 24 positions, choice first 16.
// R16: Map bit one marks a risky position.
// R17: Map bits 0 and 23 read one.
// R18: Fine step selects finer position spacing.
// R19: Counter dividers, even duty, no runt pulses.
//
// The register offsets and register access over Wishbone were left to the implementer.
module acs_aux_clock
  import acs_pkg::*;
#(
  parameter int MAP_W = MAP_BITS  // Window positions
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic [1:0]  i_clock_out_config_pins,
  input  wire logic        i_power_down_pin,
  input  wire logic        i_overrange_c,
  input  wire logic        i_overrange_d,
  input  wire logic        i_sysref,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_aux_output_c,
  output logic             o_aux_output_d,
  output logic             o_sysref_capture
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int HIST_W = STEP_COARSE * MAP_W + 2;  // History depth
  if (MAP_W < 16 || MAP_W > 32) begin : g_bad_map
    $error("MAP_W must lie between 16 and 32");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Function of one output from control and pins
  function automatic acs_fn_e fn_decode(input logic       ovrd,
                                        input logic [1:0] pins,
                                        input logic [1:0] sel,
                                        input logic       flag_en,
                                        input logic       is_d);
    logic [1:0] code;
    code = ovrd ? sel : pins;
    if (code == 2'h0) begin
      fn_decode = flag_en ? FN_OVR : FN_OFF;
    end else if (is_d && !ovrd) begin
      fn_decode = FN_DIV1;
    end else if (code == 2'h1) begin
      fn_decode = FN_DIV1;
    end else if (code == 2'h2) begin
      fn_decode = FN_DIV2;
    end else begin
      fn_decode = FN_DIV4;
    end
  endfunction

  // Output level for a function at a divider phase
  function automatic logic fn_level(input acs_fn_e    fn,
                                    input logic [2:0] cnt,
                                    input logic       flag);
    unique case (fn)
      FN_OFF:  fn_level = 1'b0;
      FN_OVR:  fn_level = flag;
      FN_DIV1: fn_level = cnt[0];
      FN_DIV2: fn_level = cnt[1];
      FN_DIV4: fn_level = cnt[2];
      default: fn_level = 1'b0;  // Unused codes stay low
    endcase
  endfunction

  // True for any clock function
  function automatic logic fn_is_clk(input acs_fn_e fn);
    fn_is_clk = (fn == FN_DIV1) || (fn == FN_DIV2) || (fn == FN_DIV4);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_s1_q;   // First stage, read by second only
  logic [3:0] pin_s2_q;   // Second stage
  logic [3:0] pin_s3_q;   // Third stage
  logic [3:0] pin_lvl_q;  // Agreed levels
  wire  [3:0] pin_raw = {i_sysref, i_power_down_pin, i_clock_out_config_pins};

  // Three flops, accept when stages two and three agree
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pin_s1_q  <= 4'h0;
      pin_s2_q  <= 4'h0;
      pin_s3_q  <= 4'h0;
      pin_lvl_q <= 4'h0;
    end else begin
      pin_s1_q  <= pin_raw;
      pin_s2_q  <= pin_s1_q;
      pin_s3_q  <= pin_s2_q;
      pin_lvl_q <= (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q | pin_s3_q));
    end
  end

  wire [1:0] cfg_pins = pin_lvl_q[1:0];  // Strap level
  wire       pd_lvl   = pin_lvl_q[2];    // Power-down level
  wire       ref_lvl  = pin_lvl_q[3];    // Timing reference level

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  acs_ctrl_s   ctrl_q;      // Control word
  logic        ack_q;       // Bus acknowledge
  logic [31:0] rdat_q;      // Read data
  logic [31:0] ctrl_word;   // Control as a bus word
  logic [31:0] wr_merge;    // Control after byte lanes
  logic [31:0] map_word;    // Window map as a bus word
  logic [31:0] status_word; // Live state word
  logic [MAP_W-1:0] map_q;  // Window map
  acs_fn_e     fn_c_q;      // Applied C function
  acs_fn_e     fn_d_q;      // Applied D function

  wire bus_req  = i_wb_cyc && i_wb_stb && !ack_q;
  wire hit_ctrl = (i_wb_adr == ADDR_CTRL);
  wire hit_map  = (i_wb_adr == ADDR_MAP);
  wire hit_stat = (i_wb_adr == ADDR_STATUS);

  assign ctrl_word = {{(32 - CTRL_CHOICE_LSB - CHOICE_BITS){1'b0}}, ctrl_q.choice, 1'b0,
                      ctrl_q.fine, ctrl_q.d_sel, ctrl_q.c_sel, ctrl_q.overrange_flag_enable,
                      ctrl_q.override};
  assign map_word    = 32'(map_q);
  assign status_word = {24'h0000_00, 1'b0, fn_d_q, 1'b0, fn_c_q};

  // Byte lane merge for control writes
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wr_merge[8*b +: 8] = i_wb_sel[b] ? i_wb_dat[8*b +: 8] : ctrl_word[8*b +: 8];
  end

  // Read mux, unmapped reads as zero
  wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                       hit_map  ? map_word :
                       hit_stat ? status_word : 32'h0000_0000;

  // One-cycle answer, write lands with the ack
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RESET[$bits(acs_ctrl_s)-1:0];
    end else begin
      ack_q  <= bus_req;
      rdat_q <= bus_req ? rd_mux : rdat_q;
      if (bus_req && i_wb_we && hit_ctrl) begin
        ctrl_q <= {wr_merge[CTRL_CHOICE_LSB +: CHOICE_BITS], wr_merge[CTRL_FINE_BIT],
                   wr_merge[CTRL_D_SEL_LSB +: 2], wr_merge[CTRL_C_SEL_LSB +: 2],
                   wr_merge[CTRL_OVERRANGE_FLAG_ENABLE_BIT], wr_merge[CTRL_OVERRIDE_BIT]};
      end
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // ----------------------------------------------------------------
  // Aux output selection
  // ----------------------------------------------------------------
  logic [2:0] div_cnt_q;  // Free running divider
  logic       aux_c_q;    // C pin flop
  logic       aux_d_q;    // D pin flop
  acs_fn_e    fn_c_d;     // Decoded C function
  acs_fn_e    fn_d_raw;   // Decoded D before C check
  acs_fn_e    fn_d_d;     // Decoded D function

  // R1 R3 R4 select decode
  assign fn_c_d   = fn_decode(ctrl_q.override, cfg_pins, ctrl_q.c_sel, ctrl_q.overrange_flag_enable, 1'b0);
  assign fn_d_raw = fn_decode(ctrl_q.override, cfg_pins, ctrl_q.d_sel, ctrl_q.overrange_flag_enable, 1'b1);
  // R5 D clock needs C clock
  assign fn_d_d   = (fn_is_clk(fn_d_raw) && !fn_is_clk(fn_c_d)) ?
                    (ctrl_q.overrange_flag_enable ? FN_OVR : FN_OFF) : fn_d_raw;

  // R19 selection applied only at divider wrap
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      div_cnt_q <= 3'h0;
      fn_c_q    <= FN_OFF;
      fn_d_q    <= FN_OFF;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
      if (div_cnt_q == DIV_LAST) begin
        fn_c_q <= fn_c_d;
        fn_d_q <= fn_d_d;
      end
    end
  end

  // R2 R7 R8 pin flops, power-down forces low
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      aux_c_q <= 1'b0;
      aux_d_q <= 1'b0;
    end else begin
      aux_c_q <= !pd_lvl && fn_level(fn_c_q, div_cnt_q, i_overrange_c);
      aux_d_q <= !pd_lvl && fn_level(fn_d_q, div_cnt_q, i_overrange_d);
    end
  end

  assign o_aux_output_c = aux_c_q;
  assign o_aux_output_d = aux_d_q;

  // ----------------------------------------------------------------
  // Timing reference window and capture
  // ----------------------------------------------------------------
  logic [HIST_W-1:0] hist_q;   // Reference history, newest at 0
  logic [MAP_W-1:0]  map_d;    // Computed window map
  logic              cap_q;    // Capture pulse flop
  logic [7:0]        win_q;    // Cycles left before map update
  logic [5:0]        pos_idx;  // History index of chosen tap

  // R18 step spacing per position
  wire [5:0] step = ctrl_q.fine ? 6'(STEP_FINE) : 6'(STEP_COARSE);
  assign pos_idx = 6'(ctrl_q.choice) * step;

  // R16 R17 map from neighbouring taps
  for (genvar k = 0; k < MAP_W; k++) begin : g_map
    if (k == 0 || k == MAP_W - 1) begin : g_edge
      assign map_d[k] = 1'b1;
    end else begin : g_mid
      assign map_d[k] = hist_q[6'(k) * step] != hist_q[6'(k + 1) * step] ||
                        hist_q[6'(k) * step] != hist_q[6'(k - 1) * step];
    end
  end

  // R11 edge of either pulse or periodic reference
  wire ref_rise = hist_q[0] && !hist_q[1];
  // R9 R10 R14 capture at the chosen delayed tap
  wire tap_rise = hist_q[pos_idx] && !hist_q[pos_idx + 6'h1];

  // History, window timer, map and capture flops
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      hist_q <= '0;
      win_q  <= 8'h00;
      map_q  <= '1;
      cap_q  <= 1'b0;
    end else begin
      hist_q <= {hist_q[HIST_W-2:0], ref_lvl};
      cap_q  <= tap_rise;
      if (ref_rise) begin
        win_q <= 8'(MAP_W) * 8'(step);
      end else if (win_q != 8'h00) begin
        win_q <= win_q - 8'h01;
      end
      // R15 map latched once the edge crossed all taps
      if (win_q == 8'h01) begin
        map_q <= map_d;
      end
    end
  end

  assign o_sysref_capture = cap_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // R8 power-down clears outputs
  AST_PD_OFF: assert property (@(posedge i_clk) disable iff (!i_resetn) // R8
    pd_lvl |=> !o_aux_output_c && !o_aux_output_d)
    else $error("Aux output high during power-down");

  // R17 window edges always set
  AST_MAP_EDGES: assert property (@(posedge i_clk) disable iff (!i_resetn) // R17
    map_q[0] && map_q[MAP_W-1])
    else $error("Window map edge bit clear");

  // R5 D clock only with C clock
  AST_D_NEEDS_C: assert property (@(posedge i_clk) disable iff (!i_resetn) // R5
    fn_is_clk(fn_d_q) |-> fn_is_clk(fn_c_q))
    else $error("D clock without C clock");

  // R3 pins give undivided D
  AST_PIN_D_DIV1: assert property (@(posedge i_clk) disable iff (!i_resetn) // R3
    !ctrl_q.override && cfg_pins != 2'h0 |-> fn_d_d == FN_DIV1)
    else $error("Pin mode D not undivided");

  // R1 pins 10 give C divided by 2
  AST_PIN_C_DIV2: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
    !ctrl_q.override && cfg_pins == 2'h2 |-> fn_c_d == FN_DIV2)
    else $error("Pin mode C not divided by 2");

  // R4 override select 3 gives divide by 4
  AST_REG_C_DIV4: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
    ctrl_q.override && ctrl_q.c_sel == 2'h3 |-> fn_c_d == FN_DIV4)
    else $error("Override C not divided by 4");

  // R2 over-range flag passes through
  AST_OVR_PASS: assert property (@(posedge i_clk) disable iff (!i_resetn) // R2
    fn_c_q == FN_OVR && !pd_lvl |=> o_aux_output_c == $past(i_overrange_c))
    else $error("Over-range flag not on C");

  // R19 selection changes only at wrap
  AST_SWITCH_WRAP: assert property (@(posedge i_clk) disable iff (!i_resetn) // R19
    fn_c_q != $past(fn_c_q) |-> $past(div_cnt_q) == DIV_LAST)
    else $error("Function changed mid period");

  // R19 divide by 4 high for four cycles
  AST_DIV4_HIGH: assert property (@(posedge i_clk) disable iff (!i_resetn) // R19
    fn_c_q == FN_DIV4 && div_cnt_q == 3'h4 && !pd_lvl ##1 !pd_lvl [*3]
      |=> o_aux_output_c && $past(o_aux_output_c, 3) && !$past(o_aux_output_c, 4))
    else $error("Divide by 4 duty wrong");

  // R11 capture is a single-cycle pulse
  AST_CAP_PULSE: assert property (@(posedge i_clk) disable iff (!i_resetn) // R11
    o_sysref_capture |=> !o_sysref_capture)
    else $error("Capture pulse wider than one cycle");

endmodule : acs_aux_clock

// File: src/acs_pkg.sv
package acs_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;  // Control word
  localparam logic [7:0] ADDR_MAP    = 8'h04;  // Window map, read only
  localparam logic [7:0] ADDR_STATUS = 8'h08;  // Live state, read only

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_OVERRIDE_BIT = 0;   // Pin override enable
  localparam int CTRL_OVERRANGE_FLAG_ENABLE_BIT   = 1;   // Over-range flag enable
  localparam int CTRL_C_SEL_LSB    = 2;   // C select, 2 bits
  localparam int CTRL_D_SEL_LSB    = 4;   // D select, 2 bits
  localparam int CTRL_FINE_BIT     = 6;   // Fine step
  localparam int CTRL_CHOICE_LSB   = 8;   // Sample choice, 4 bits

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;  // Pins govern
  localparam logic [2:0]  DIV_LAST     = 3'h7;  // Divider wrap point
  localparam int          MAP_BITS     = 24;    // Window positions
  localparam int          CHOICE_BITS  = 4;     // Selectable first 16
  localparam int          STEP_COARSE  = 2;     // Cycles per coarse step
  localparam int          STEP_FINE    = 1;     // Cycles per fine step

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Function driven on one aux output
  typedef enum logic [2:0] {
    FN_OFF,
    FN_OVR,
    FN_DIV1,
    FN_DIV2,
    FN_DIV4
  } acs_fn_e;

  // Software control word
  typedef struct packed {
    logic [CHOICE_BITS-1:0] choice;     // Sampling position index
    logic                   fine;       // Fine step spacing
    logic [1:0]             d_sel;      // D reference select
    logic [1:0]             c_sel;      // C reference select
    logic                   overrange_flag_enable;     // Over-range flag enable
    logic                   override;   // Registers replace pins
  } acs_ctrl_s;

endpackage : acs_pkg

// File: dv/acs_far_side.sv
// Far side: timing reference source and downstream clock consumer
module acs_far_side (
  input  wire logic        i_clk,
  input  wire logic        i_pulse,   // One-shot reference request
  input  wire logic [15:0] i_period,  // Periodic rate, zero for off
  input  wire logic        i_clear,   // Clear edge counters
  input  wire logic        i_aux_c,   // Aux output C pin
  input  wire logic        i_aux_d,   // Aux output D pin
  output logic             o_sysref,  // Reference pin drive
  output logic [15:0]      o_edges_c, // Rising edges on C
  output logic [15:0]      o_edges_d  // Rising edges on D
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Reference generator
  // ----------------------------------------------------------------
  logic [15:0] cnt_q = 16'h0000;  // Periodic phase
  logic [2:0]  hold_q = 3'h0;     // Remaining pulse cycles
  logic        c_q = 1'b0;        // Last C level
  logic        d_q = 1'b0;        // Last D level

  initial begin
    o_sysref = 1'b0;
    o_edges_c = 16'h0000;
    o_edges_d = 16'h0000;
  end

  always @(posedge i_clk) begin
    if (i_period != 16'h0000) begin
      cnt_q <= (cnt_q >= i_period - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
      o_sysref <= (cnt_q < (i_period >> 1));
    end else begin
      cnt_q <= 16'h0000;
      o_sysref <= (hold_q != 3'h0) | i_pulse;
    end
    hold_q <= i_pulse ? 3'h3 : ((hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0);
  end

  // ----------------------------------------------------------------
  // Downstream consumer: counts rising edges
  // ----------------------------------------------------------------
  // consumers on C and D
  always @(posedge i_clk) begin
    c_q <= i_aux_c;
    d_q <= i_aux_d;
    if (i_clear) begin
      o_edges_c <= 16'h0000;
      o_edges_d <= 16'h0000;
    end else begin
      o_edges_c <= o_edges_c + {15'h0000, (i_aux_c && !c_q)};
      o_edges_d <= o_edges_d + {15'h0000, (i_aux_d && !d_q)};
    end
  end
endmodule // acs_far_side

// File: dv/test_aux_clock_out_and_sysref_capture.sv
// Bench: bus tasks, aux output modes and reference capture
module test_aux_clock_out_and_sysref_capture
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, resetn = 1'b0, pd = 1'b0, aux_output_c = 1'b0, aux_output_d = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, pulse = 1'b0, clear = 1'b0;
  logic        ack, auxc, auxd, sref, cap;
  logic [1:0]  pins = 2'h1;  // Strapped for plain reference at power-up
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic [15:0] period = 16'h0000, edges_c, edges_d;
  int          mismatches = 0, tests_run = 0, d0, d1, k;

  acs_aux_clock dut (.i_clk(clk), .i_resetn(resetn), .i_clock_out_config_pins(pins),
    .i_power_down_pin(pd), .i_overrange_c(aux_output_c), .i_overrange_d(aux_output_d), .i_sysref(sref),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_aux_output_c(auxc),
    .o_aux_output_d(auxd), .o_sysref_capture(cap));

  acs_far_side far (.i_clk(clk), .i_pulse(pulse), .i_period(period), .i_clear(clear),
    .i_aux_c(auxc), .i_aux_d(auxd), .o_sysref(sref), .o_edges_c(edges_c),
    .o_edges_d(edges_d));

  initial forever #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input string nm);
    mismatches++;
    $display("mismatch %s expected answer seen none", nm);
    finish_test();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) hang("wb_ack");
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  // Count rising edges over 64 cycles
  task automatic edges(input int ec, input int ed);
    clear <= 1'b1;
    tick(1);
    clear <= 1'b0;
    tick(65);
    check("edges_c", ec, edges_c);
    check("edges_d", ed, edges_d);
  endtask

  // Cycles from reference request to capture pulse
  task automatic sref_delay(output int d);
    pulse <= 1'b1;
    tick(1);
    pulse <= 1'b0;
    d = 0;
    while (cap !== 1'b1 && d < 300) begin
      tick(1);
      d++;
    end
    if (cap !== 1'b1) hang("capture");
    tick(100);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(12);
    resetn <= 1'b1;
    tick(30);
    edges(32, 32);
    rd(ADDR_CTRL);
    check("ctrl", CTRL_RESET, q);
    rd(ADDR_MAP);
    check("map", 32'h00FF_FFFF, q);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C);
    check("unmapped", 32'h0000_0000, q);
    wr(ADDR_MAP, 32'h0000_0000);
    rd(ADDR_MAP);
    check("map_ro", 32'h00FF_FFFF, q);
    $display("test reset_bus done");
    // Strap patterns, no register override
    for (k = 1; k < 4; k++) begin
      pins <= k[1:0];
      tick(40);
      rd(ADDR_STATUS);
      check("status", 32'h0000_0020 | (k + 1), q & 32'h0000_0077);
      edges(32 >> (k - 1), 32);
    end
    pins <= 2'h0;
    tick(40);
    rd(ADDR_STATUS);
    check("status_off", 32'h0000_0000, q & 32'h0000_0077);
    wr(ADDR_CTRL, 32'h0000_0001 << CTRL_OVERRANGE_FLAG_ENABLE_BIT);
    aux_output_c <= 1'b1;
    tick(20);
    rd(ADDR_STATUS);
    check("status_ovr", 32'h0000_0011, q & 32'h0000_0077);
    check("aux_c_flag", 32'h0000_0001, {31'h0, auxc});
    aux_output_d <= 1'b1;
    aux_output_c <= 1'b0;
    tick(10);
    check("aux_c_low", 32'h0000_0000, {31'h0, auxc});
    check("aux_d_flag", 32'h0000_0001, {31'h0, auxd});
    pins <= 2'h1;
    tick(20);
    rd(ADDR_STATUS);
    check("status_prio", 32'h0000_0022, q & 32'h0000_0077);
    $display("test pins done");
    // Register override, pins ignored
    pins <= 2'h3;
    for (k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, 32'h0000_0001 | (k << CTRL_C_SEL_LSB) | (3 << CTRL_D_SEL_LSB));
      tick(40);
      rd(ADDR_STATUS);
      check("status_ovrd", (k == 0) ? 0 : (32'h0000_0040 | (k + 1)),
            q & 32'h0000_0077);
      edges((k == 0) ? 0 : (32 >> (k - 1)), (k == 0) ? 0 : 8);
    end
    bus(1'b1, ADDR_CTRL, 32'hFFFF_FFFF, 4'h2);
    rd(ADDR_CTRL);
    check("ctrl_lane", 32'h0000_0F3D, q & 32'h0000_0F7F);
    $display("test override done");
    wr(ADDR_CTRL, 32'h0000_0000);
    pins <= 2'h1;
    pd <= 1'b1;
    tick(20);
    edges(0, 0);
    check("aux_pd", 32'h0000_0000, {30'h0, auxc, auxd});
    pd <= 1'b0;
    $display("test power_down done");
    // Reference capture positions
    sref_delay(d0);
    wr(ADDR_CTRL, 32'h0000_0004 << CTRL_CHOICE_LSB);
    sref_delay(d1);
    check("coarse_step", 4 * STEP_COARSE, d1 - d0);
    wr(ADDR_CTRL, (32'h0000_0001 << CTRL_FINE_BIT) | (32'h0000_000F << CTRL_CHOICE_LSB));
    sref_delay(d1);
    check("fine_step", 15 * STEP_FINE, d1 - d0);
    rd(ADDR_MAP);
    check("map_edges", 32'h0080_0001, q & 32'hFF80_0001);
    wr(ADDR_CTRL, 32'h0000_0000);
    period <= 16'h003C;
    tick(200);
    k = 0;
    repeat (600) begin
      tick(1);
      if (cap === 1'b1) k++;
    end
    check("captures", 10, k);
    $display("test sysref done");
    finish_test();
  end
endmodule // test_aux_clock_out_and_sysref_capture
